// ==== src/mmd_pkg.sv ====
// constants, types and register map of the memory map decoder
package mmd_pkg;

	// register indices as printed; byte address is four times the index
	localparam logic [15:0] MAP_IDX  = 16'h103D;
	localparam logic [15:0] CFG_IDX  = 16'h103F;
	localparam logic [15:0] STAT_IDX = 16'h1040;
	localparam logic [17:0] MAP_ADDR  = {MAP_IDX, 2'h0};
	localparam logic [17:0] CFG_ADDR  = {CFG_IDX, 2'h0};
	localparam logic [17:0] STAT_ADDR = {STAT_IDX, 2'h0};

	// values after reset and the write mask of the configuration register
	localparam logic [7:0] MAP_RESET = 8'h01;
	localparam logic [7:0] CFG_RESET = 8'h0F;
	localparam logic [7:0] CFG_WMASK = 8'h0F;

	// configuration bit positions
	localparam int CFG_ROM_BIT = 1;
	localparam int CFG_EEP_BIT = 0;

	// status bit positions
	localparam int STAT_LOCK_BIT   = 0;
	localparam int STAT_CLOSED_BIT = 1;
	localparam int STAT_MODE_LSB   = 2;

	// write window after reset, in E clock cycles
	localparam logic [6:0] INIT_WINDOW_CYC = 7'h40;

	// fixed address ranges
	localparam logic [15:0] ROM_BASE    = 16'hE000;
	localparam logic [15:0] EEP_LO      = 16'hB600;
	localparam logic [15:0] EEP_HI      = 16'hB7FF;
	localparam logic [15:0] BOOT_LO     = 16'hBF40;
	localparam logic [15:0] BOOT_HI     = 16'hBFFF;
	localparam logic [15:0] VEC_LO      = 16'hFFC0;
	localparam logic [15:0] VEC_TEST_HI = 16'hFFEF;
	localparam logic [7:0]  VEC_PAGE    = 8'hBF;

	// value of the undriven internal data bus
	localparam logic [7:0] IDLE_BUS = 8'hFF;

	// one-hot select positions
	localparam int SEL_REG  = 0;
	localparam int SEL_RAM  = 1;
	localparam int SEL_ROM  = 2;
	localparam int SEL_EEP  = 3;
	localparam int SEL_BOOT = 4;
	localparam int SEL_EXT  = 5;
	localparam int SEL_NONE = 6;
	localparam int SEL_W    = 7;

	typedef enum logic [1:0] {
		MMD_MODE_SINGLE = 2'h0,
		MMD_MODE_EXPAND = 2'h1,
		MMD_MODE_BOOT   = 2'h2,
		MMD_MODE_TEST   = 2'h3
	} mmd_mode_t;

	typedef enum logic {
		MMD_APB_IDLE,
		MMD_APB_ACK
	} mmd_apb_st_t;

	typedef struct packed {
		mmd_apb_st_t       apb_st;
		logic              pready;
		logic              pslverr;
		logic [31:0]       prdata;
		logic [7:0]        map;
		logic [7:0]        cfg;
		logic [6:0]        cnt;
		logic              locked;
		logic [SEL_W-1:0]  sel;
		logic [15:0]       iaddr;
		logic              iwrite;
		logic [7:0]        iwdata;
		logic [15:0]       xaddr;
		logic              xas;
		logic              xread;
		logic [7:0]        xdata;
		logic              xoe;
		logic              rd_pend;
		logic [7:0]        rdata;
		logic              rvalid;
	} mmd_state_t;

endpackage

// ==== src/mmd_decode.sv ====
// priority address decoder for one access
module mmd_decode (
	// access
	input  wire logic [15:0]                 addr_in,
	input  wire logic [1:0]                  mode_in,
	// mapping and enables
	input  wire logic [7:0]                  map_in,
	input  wire logic [7:0]                  cfg_in,
	// result
	output logic      [mmd_pkg::SEL_W-1:0]   sel_out,
	output logic      [15:0]                 eaddr_out
);

	function automatic logic page_hit(input logic [15:0] a, input logic [3:0] nib);
		return a[15:12] == nib;
	endfunction

	logic vec_boot;
	logic vec_test;
	logic vec;
	logic reg_hit;
	logic ram_hit;
	logic rom_hit;
	logic eep_hit;
	logic boot_hit;
	logic ext_mode;

	always_comb begin
		vec_boot = (mode_in == mmd_pkg::MMD_MODE_BOOT) && (addr_in >= mmd_pkg::VEC_LO);
		vec_test = (mode_in == mmd_pkg::MMD_MODE_TEST) && (addr_in >= mmd_pkg::VEC_LO)
			&& (addr_in <= mmd_pkg::VEC_TEST_HI);
		vec = vec_boot || vec_test;
		eaddr_out = addr_in;
		if (vec) begin
			eaddr_out = {mmd_pkg::VEC_PAGE, addr_in[7:0]};
		end
		reg_hit = page_hit(eaddr_out, map_in[3:0]) && (eaddr_out[11:6] == 6'h00)
			&& !vec;
		ram_hit = page_hit(eaddr_out, map_in[7:4]) && (eaddr_out[11:8] == 4'h0)
			&& !vec;
		rom_hit = (cfg_in[mmd_pkg::CFG_ROM_BIT] || (mode_in == mmd_pkg::MMD_MODE_SINGLE))
			&& (eaddr_out >= mmd_pkg::ROM_BASE);
		eep_hit = cfg_in[mmd_pkg::CFG_EEP_BIT] && (eaddr_out >= mmd_pkg::EEP_LO)
			&& (eaddr_out <= mmd_pkg::EEP_HI);
		boot_hit = (mode_in == mmd_pkg::MMD_MODE_BOOT) && (eaddr_out >= mmd_pkg::BOOT_LO)
			&& (eaddr_out <= mmd_pkg::BOOT_HI);
		ext_mode = (mode_in == mmd_pkg::MMD_MODE_EXPAND) || (mode_in == mmd_pkg::MMD_MODE_TEST);
		sel_out = '0;
		// exactly one select, highest priority first
		if (vec_test) begin
			sel_out[mmd_pkg::SEL_EXT] = 1'b1;
		end else if (reg_hit) begin
			sel_out[mmd_pkg::SEL_REG] = 1'b1;
		end else if (ram_hit) begin
			sel_out[mmd_pkg::SEL_RAM] = 1'b1;
		end else if (rom_hit) begin
			sel_out[mmd_pkg::SEL_ROM] = 1'b1;
		end else if (eep_hit) begin
			sel_out[mmd_pkg::SEL_EEP] = 1'b1;
		end else if (boot_hit) begin
			sel_out[mmd_pkg::SEL_BOOT] = 1'b1;
		end else if (ext_mode) begin
			sel_out[mmd_pkg::SEL_EXT] = 1'b1;
		end else begin
			sel_out[mmd_pkg::SEL_NONE] = 1'b1;
		end
	end

endmodule

// ==== src/mmd_top.sv ====
// memory map decoder top: mapping registers, decode pipeline, expansion bus
module mmd_top (
	// clock and reset
	input  wire logic                        core_clk_in,
	input  wire logic                        rstn_in,
	// apb slave
	input  wire logic                        psel_in,
	input  wire logic                        penable_in,
	input  wire logic                        pwrite_in,
	input  wire logic [17:0]                 paddr_in,
	input  wire logic [31:0]                 pwdata_in,
	output logic      [31:0]                 prdata_out,
	output logic                             pready_out,
	output logic                             pslverr_out,
	// operating mode
	input  wire logic [1:0]                  mode_in,
	// core access request
	input  wire logic                        cpu_valid_in,
	input  wire logic                        cpu_read_in,
	input  wire logic [15:0]                 cpu_addr_in,
	input  wire logic [7:0]                  cpu_wdata_in,
	// internal resource read data
	input  wire logic [7:0]                  reg_rdata_in,
	input  wire logic                        reg_impl_in,
	input  wire logic [7:0]                  ram_rdata_in,
	input  wire logic [7:0]                  rom_rdata_in,
	input  wire logic [7:0]                  eep_rdata_in,
	input  wire logic [7:0]                  boot_rdata_in,
	// internal resource selects
	output logic      [mmd_pkg::SEL_W-1:0]   sel_out,
	output logic      [15:0]                 int_addr_out,
	output logic                             int_write_out,
	output logic      [7:0]                  int_wdata_out,
	// expansion bus
	output logic      [15:0]                 exp_addr_out,
	output logic                             exp_as_out,
	output logic                             exp_read_out,
	output logic      [7:0]                  exp_data_out,
	output logic                             exp_data_oe_out,
	input  wire logic [7:0]                  exp_data_in,
	// core read answer
	output logic      [7:0]                  cpu_rdata_out,
	output logic                             cpu_rvalid_out
);

	mmd_pkg::mmd_state_t s_r;
	mmd_pkg::mmd_state_t s_nxt;

	logic [mmd_pkg::SEL_W-1:0] dec_sel;
	logic [15:0]               dec_eaddr;
	logic                      apb_setup;
	logic                      apb_done;
	logic                      win_open;
	logic                      addr_ok;
	logic [31:0]               rd_word;

	mmd_decode u_decode (
		.addr_in   (cpu_addr_in),
		.mode_in   (mode_in),
		.map_in    (s_r.map),
		.cfg_in    (s_r.cfg),
		.sel_out   (dec_sel),
		.eaddr_out (dec_eaddr)
	);

	localparam mmd_pkg::mmd_state_t STATE_RESET = '{
		apb_st:  mmd_pkg::MMD_APB_IDLE,
		pready:  1'b0,
		pslverr: 1'b0,
		prdata:  32'h0000_0000,
		map:     mmd_pkg::MAP_RESET,
		cfg:     mmd_pkg::CFG_RESET,
		cnt:     7'h00,
		locked:  1'b0,
		sel:     7'h00,
		iaddr:   16'h0000,
		iwrite:  1'b0,
		iwdata:  8'h00,
		xaddr:   16'h0000,
		xas:     1'b0,
		xread:   1'b1,
		xdata:   8'h00,
		xoe:     1'b0,
		rd_pend: 1'b0,
		rdata:   8'h00,
		rvalid:  1'b0
	};

	always_comb begin
		s_nxt = s_r;

		// write window counter, saturates once closed
		win_open = s_r.cnt < mmd_pkg::INIT_WINDOW_CYC;
		if (win_open) begin
			s_nxt.cnt = s_r.cnt + 7'h01;
		end

		// apb register access
		apb_setup = psel_in && !penable_in;
		apb_done  = psel_in && penable_in && s_r.pready;
		addr_ok   = (paddr_in == mmd_pkg::MAP_ADDR) || (paddr_in == mmd_pkg::CFG_ADDR)
			|| (paddr_in == mmd_pkg::STAT_ADDR);
		rd_word = 32'h0000_0000;
		case (paddr_in)
			mmd_pkg::MAP_ADDR: begin
				rd_word[7:0] = s_r.map;
			end
			mmd_pkg::CFG_ADDR: begin
				rd_word[7:0] = s_r.cfg;
			end
			mmd_pkg::STAT_ADDR: begin
				rd_word[mmd_pkg::STAT_LOCK_BIT]   = s_r.locked;
				rd_word[mmd_pkg::STAT_CLOSED_BIT] = !win_open;
				rd_word[mmd_pkg::STAT_MODE_LSB +: 2] = mode_in;
			end
			default: begin
				rd_word = 32'h0000_0000;
			end
		endcase

		case (s_r.apb_st)
			mmd_pkg::MMD_APB_IDLE: begin
				s_nxt.pready  = 1'b0;
				s_nxt.pslverr = 1'b0;
				if (apb_setup) begin
					s_nxt.apb_st  = mmd_pkg::MMD_APB_ACK;
					s_nxt.pready  = 1'b1;
					s_nxt.pslverr = !addr_ok;
					s_nxt.prdata  = pwrite_in ? 32'h0000_0000 : rd_word;
				end
			end
			mmd_pkg::MMD_APB_ACK: begin
				if (apb_done) begin
					s_nxt.apb_st  = mmd_pkg::MMD_APB_IDLE;
					s_nxt.pready  = 1'b0;
					s_nxt.pslverr = 1'b0;
					if (pwrite_in && addr_ok) begin
						if (paddr_in == mmd_pkg::MAP_ADDR && win_open && !s_r.locked) begin
							s_nxt.map    = pwdata_in[7:0];
							s_nxt.locked = 1'b1;
						end
						if (paddr_in == mmd_pkg::CFG_ADDR) begin
							s_nxt.cfg = pwdata_in[7:0] & mmd_pkg::CFG_WMASK;
						end
					end
				end
			end
			default: begin
				s_nxt.apb_st = mmd_pkg::MMD_APB_IDLE;
				s_nxt.pready = 1'b0;
			end
		endcase

		// access stage: selects and expansion bus, one cycle per access
		s_nxt.sel    = '0;
		s_nxt.iwrite = 1'b0;
		s_nxt.xas    = 1'b0;
		s_nxt.xoe    = 1'b0;
		s_nxt.rd_pend = 1'b0;
		if (cpu_valid_in) begin
			s_nxt.sel    = dec_sel;
			s_nxt.iaddr  = dec_eaddr;
			s_nxt.iwrite = !cpu_read_in && !dec_sel[mmd_pkg::SEL_EXT]
				&& !dec_sel[mmd_pkg::SEL_NONE];
			s_nxt.iwdata = cpu_wdata_in;
			// bus cycle shown for internal targets too
			s_nxt.xaddr  = dec_eaddr;
			s_nxt.xas    = 1'b1;
			s_nxt.xread  = cpu_read_in;
			s_nxt.xdata  = cpu_wdata_in;
			s_nxt.xoe    = !cpu_read_in;
			s_nxt.rd_pend = cpu_read_in;
		end

		// answer stage: pick the source chosen in the access stage
		s_nxt.rvalid = s_r.rd_pend;
		if (s_r.rd_pend) begin
			if (s_r.sel[mmd_pkg::SEL_REG]) begin
				s_nxt.rdata = reg_impl_in ? reg_rdata_in : mmd_pkg::IDLE_BUS;
			end else if (s_r.sel[mmd_pkg::SEL_RAM]) begin
				s_nxt.rdata = ram_rdata_in;
			end else if (s_r.sel[mmd_pkg::SEL_ROM]) begin
				s_nxt.rdata = rom_rdata_in;
			end else if (s_r.sel[mmd_pkg::SEL_EEP]) begin
				s_nxt.rdata = eep_rdata_in;
			end else if (s_r.sel[mmd_pkg::SEL_BOOT]) begin
				s_nxt.rdata = boot_rdata_in;
			end else if (s_r.sel[mmd_pkg::SEL_EXT]) begin
				s_nxt.rdata = exp_data_in;
			end else begin
				s_nxt.rdata = mmd_pkg::IDLE_BUS;
			end
		end
	end

	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			s_r <= STATE_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	// outputs straight from the state register
	assign prdata_out      = s_r.prdata;
	assign pready_out      = s_r.pready;
	assign pslverr_out     = s_r.pslverr;
	assign sel_out         = s_r.sel;
	assign int_addr_out    = s_r.iaddr;
	assign int_write_out   = s_r.iwrite;
	assign int_wdata_out   = s_r.iwdata;
	assign exp_addr_out    = s_r.xaddr;
	assign exp_as_out      = s_r.xas;
	assign exp_read_out    = s_r.xread;
	assign exp_data_out    = s_r.xdata;
	assign exp_data_oe_out = s_r.xoe;
	assign cpu_rdata_out   = s_r.rdata;
	assign cpu_rvalid_out  = s_r.rvalid;

endmodule

// ==== tb/mmd_assertions.sv ====
// concurrent checks on the decoder top ports
module mmd_assertions (
	// clock and reset
	input wire logic        core_clk_in,
	input wire logic        rstn_in,
	// core side
	input wire logic [1:0]  mode_in,
	input wire logic        cpu_valid_in,
	input wire logic        cpu_read_in,
	input wire logic [15:0] cpu_addr_in,
	input wire logic [7:0]  cpu_wdata_in,
	input wire logic        reg_impl_in,
	input wire logic [7:0]  ram_rdata_in,
	input wire logic [7:0]  exp_data_in,
	// decoder outputs
	input wire logic [6:0]  sel_out,
	input wire logic [15:0] int_addr_out,
	input wire logic [15:0] exp_addr_out,
	input wire logic        exp_as_out,
	input wire logic        exp_read_out,
	input wire logic [7:0]  exp_data_out,
	input wire logic        exp_data_oe_out,
	input wire logic [7:0]  cpu_rdata_out,
	input wire logic        cpu_rvalid_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rstn_in);
	a_one_select: assert property (cpu_valid_in |=> $onehot(sel_out))
		else $error("select not one-hot");
	a_strobe_dir: assert property (cpu_valid_in |=>
		exp_as_out && exp_read_out == $past(cpu_read_in))
		else $error("strobe or direction wrong");
	a_write_out: assert property (cpu_valid_in && !cpu_read_in |=>
		exp_data_oe_out && exp_data_out == $past(cpu_wdata_in))
		else $error("write data not on bus");
	a_boot_vec: assert property (
		cpu_valid_in && mode_in == 2'h2 && cpu_addr_in >= 16'hFFC0 |=>
		sel_out[4] && int_addr_out == {8'hBF, $past(cpu_addr_in[7:0])})
		else $error("boot vector not remapped");
	a_test_vec: assert property (
		cpu_valid_in && mode_in == 2'h3 && cpu_addr_in inside {[16'hFFC0:16'hFFEF]} |=>
		sel_out[5] && exp_addr_out == {8'hBF, $past(cpu_addr_in[7:0])})
		else $error("test vector not external");
	a_unused_idle: assert property (
		sel_out[0] && exp_read_out && !reg_impl_in |=> cpu_rdata_out == 8'hFF)
		else $error("unused register not idle");
	a_ram_wins: assert property (sel_out[1] && exp_read_out |=>
		cpu_rdata_out == $past(ram_rdata_in))
		else $error("ram read data wrong");
	a_ext_read: assert property (sel_out[5] && exp_read_out |=>
		cpu_rvalid_out && cpu_rdata_out == $past(exp_data_in))
		else $error("external read data wrong");
endmodule

// ==== tb/mmd_ext_model.sv ====
// behavioural external memory on the expansion bus
module mmd_ext_model (
	// bus from the decoder
	input  wire logic        clk_in,
	input  wire logic [15:0] addr_in,
	input  wire logic        as_in,
	input  wire logic        read_in,
	input  wire logic [7:0]  data_in,
	input  wire logic        oe_in,
	// data towards the decoder
	output logic      [7:0]  data_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [65536];
	logic [7:0] last = 8'h00;
	initial for (int i = 0; i < 65536; i++) mem[i] = 8'(i ^ (i >> 8));
	// drives only on reads, garbage otherwise
	assign data_out = (as_in && read_in) ? mem[addr_in] : ~last;
	always @(posedge clk_in) begin
		if (as_in && read_in) last <= mem[addr_in];
		if (oe_in) mem[addr_in] <= data_in;
	end
endmodule

// ==== tb/tb_memory_map_decoder.sv ====
// self-checking bench for the memory map decoder
module tb_memory_map_decoder;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk_in = 0, rstn_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0, e;
	logic cpu_valid_in = 0, cpu_read_in = 0, reg_impl_in = 0, pready_out, pslverr_out;
	logic int_write_out, exp_as_out, exp_read_out, exp_data_oe_out, cpu_rvalid_out;
	logic [1:0] mode_in = 1;
	logic [mmd_pkg::SEL_W-1:0] sel_out;
	logic [7:0] cpu_wdata_in = 0, int_wdata_out, exp_data_out, exp_data_in, cpu_rdata_out;
	logic [15:0] cpu_addr_in = 0, int_addr_out, exp_addr_out;
	logic [17:0] paddr_in = 0;
	logic [31:0] pwdata_in = 0, prdata_out, srcd = 0, seed = 24, r;
	wire [7:0] reg_rdata_in = srcd[7:0], ram_rdata_in = srcd[15:8], rom_rdata_in = srcd[23:16];
	wire [7:0] eep_rdata_in = srcd[31:24], boot_rdata_in = srcd[7:0] ^ 8'h5A;
	int mismatches = 0, num_checks = 0, mp = 1, cf = 15;
	logic [7:0] xm [int];
	mmd_top DUT (.*);
	mmd_ext_model u_ext (.clk_in(core_clk_in), .addr_in(exp_addr_out), .as_in(exp_as_out),
		.read_in(exp_read_out), .data_in(exp_data_out), .oe_in(exp_data_oe_out),
		.data_out(exp_data_in));
	always #50 core_clk_in = ~core_clk_in;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic int msel(int a, int m);
		if (m > 1 && a >= 'hFFC0 && (m == 2 || a <= 'hFFEF)) return m == 2 ? 4 : 5;
		if (a >> 12 == mp % 16 && a % 4096 < 64) return 0;
		if (a >> 12 == mp / 16 && a % 4096 < 256) return 1;
		if (a >= 'hE000 && (m == 0 || cf[1])) return 2;
		if (a >= 'hB600 && a <= 'hB7FF && cf[0]) return 3;
		if (m == 2 && a >= 'hBF40 && a < 'hC000) return 4;
		return m % 2 ? 5 : 6;
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		num_checks++;
		if (g !== x) begin
			mismatches++;
			$display("CHECK FAILED %0t got %h exp %h", $time, g, x);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [15:0] i, input logic [7:0] d);
		@(posedge core_clk_in);
		psel_in <= 1;
		pwrite_in <= w;
		paddr_in <= {i, 2'h0};
		pwdata_in <= {24'h0, d};
		@(posedge core_clk_in);
		penable_in <= 1;
		do @(posedge core_clk_in); while (pready_out !== 1);
		r = prdata_out;
		e = pslverr_out;
		psel_in <= 0;
		penable_in <= 0;
	endtask
	task automatic acc(input int m);
		logic [15:0] a;
		logic rd;
		int es, ea;
		logic [7:0] ex;
		r = rnd();
		a = r[15:0];
		case (r[17:16])
			0: begin
				a[11:6] = 0;
				if (r[20]) a[15:12] = 4'(mp);
			end
			1: a[15:9] = 7'h5B;
			2: a[15:6] = 10'h3FF;
			default: if (r[20]) a[15:8] = {4'(mp / 16), 4'h0};
		endcase
		rd = r[18] | (m > 1);
		es = msel(a, m);
		ea = (m > 1 && a >= 'hFFC0 && (m == 2 || a <= 'hFFEF)) ? 'hBF00 + a % 256 : a;
		mode_in <= m[1:0];
		cpu_valid_in <= 1;
		cpu_read_in <= rd;
		cpu_addr_in <= a;
		cpu_wdata_in <= r[31:24];
		reg_impl_in <= r[19];
		srcd <= rnd();
		@(posedge core_clk_in);
		cpu_valid_in <= 0;
		@(posedge core_clk_in);
		chk(sel_out, 1 << es);
		chk({exp_as_out, exp_read_out}, {1'b1, rd});
		chk(exp_addr_out, ea);
		chk(exp_data_oe_out, !rd);
		chk(int_addr_out, ea);
		chk({int_write_out, int_wdata_out}, {!rd && es < 5, r[31:24]});
		if (!rd) begin
			chk({exp_data_oe_out, exp_data_out}, {1'b1, r[31:24]});
			xm[ea] = r[31:24];
		end
		case (es)
			0: ex = reg_impl_in ? srcd[7:0] : 8'hFF;
			1: ex = srcd[15:8];
			2: ex = srcd[23:16];
			3: ex = srcd[31:24];
			4: ex = srcd[7:0] ^ 8'h5A;
			5: ex = xm.exists(ea) ? xm[ea] : 8'(ea ^ (ea >> 8));
			default: ex = 8'hFF;
		endcase
		@(posedge core_clk_in);
		if (rd) chk({cpu_rvalid_out, cpu_rdata_out}, {1'b1, ex});
	endtask
	initial begin
		#2000000;
		mismatches++;
		print_verdict();
	end
	initial begin
		repeat (2) @(posedge core_clk_in);
		rstn_in <= 1;
		apb(0, mmd_pkg::MAP_IDX, 0);
		chk(r, 32'h01);
		apb(0, mmd_pkg::CFG_IDX, 0);
		chk(r, 32'h0F);
		apb(0, 16'h2000, 0);
		chk(e, 1);
		apb(1, mmd_pkg::MAP_IDX, 8'hF4);
		apb(1, mmd_pkg::MAP_IDX, 8'h22);
		apb(0, mmd_pkg::MAP_IDX, 0);
		chk(r, 32'hF4);
		mp = 'hF4;
		for (int k = 0; k < 8; k++) begin
			if (k == 4) begin
				apb(1, mmd_pkg::CFG_IDX, 8'hF0);
				cf = 0;
			end
			repeat (40) acc(k % 4);
		end
		apb(0, mmd_pkg::STAT_IDX, 0);
		chk(r, 32'(mode_in) << mmd_pkg::STAT_MODE_LSB
			| 1 << mmd_pkg::STAT_CLOSED_BIT | 1 << mmd_pkg::STAT_LOCK_BIT);
		rstn_in <= 0;
		@(posedge core_clk_in);
		rstn_in <= 1;
		mp = 1;
		cf = 15;
		repeat (70) @(posedge core_clk_in);
		apb(1, mmd_pkg::MAP_IDX, 8'h33);
		apb(0, mmd_pkg::MAP_IDX, 0);
		chk(r, 32'h01);
		repeat (40) acc(1);
		rstn_in <= 0;
		@(posedge core_clk_in);
		rstn_in <= 1;
		apb(1, mmd_pkg::MAP_IDX, 8'hEE);
		apb(0, mmd_pkg::MAP_IDX, 0);
		chk(r, 32'hEE);
		mp = 'hEE;
		for (int k = 0; k < 4; k++) repeat (20) acc(k);
		print_verdict();
	end
endmodule
bind mmd_top mmd_assertions u_chk (.*);
